// ===== ciq_host.sv
`timescale 1ns/1ps
module ciq_host (
   input logic clk,
   input logic req_ready,
   input logic wr_ready,
   input logic rsp_valid,
   input logic [ciq_pkg::DATA_W-1:0] rsp_data,
   input logic done,
   input logic [ciq_pkg::CODE_W-1:0] done_code,
   output logic req_valid,
   output logic req_write,
   output logic [ciq_pkg::ID_W-1:0] req_dest,
   output logic [ciq_pkg::ADDR_W-1:0] req_addr,
   output logic [ciq_pkg::LEN_W-1:0] req_len,
   output logic wr_valid,
   output logic [ciq_pkg::DATA_W-1:0] wr_data
);
   import ciq_pkg::*;
   logic [DATA_W-1:0] rd_q[$];
   logic [DATA_W-1:0] wq[$];
   logic [CODE_W-1:0] code = '0;
   bit got_done = 0;
   bit tmo = 0;
   initial begin
      {req_valid, req_write, wr_valid, req_dest, req_addr, req_len, wr_data} = '0;
   end
   always @(posedge clk) begin
      if (rsp_valid) rd_q.push_back(rsp_data);
      if (done) begin
         got_done = 1;
         code = done_code;
      end
   end
   // ------------------------------------------------------------
   // One transfer; the caller keeps lengths legal except on purpose
   // ------------------------------------------------------------
   // byte address, bounded length
   task automatic xfer(input logic wr, input logic [ID_W-1:0] dst,
         input logic [ADDR_W-1:0] adr, input logic [LEN_W-1:0] len, input bit want);
      int n;
      rd_q.delete();
      got_done = 0;
      n = 0;
      req_valid <= 1'b1;
      req_write <= wr;
      req_dest <= dst;
      req_addr <= adr;
      req_len <= len;
      do begin
         @(posedge clk);
         n++;
      end while (!req_ready && n < 40);
      // A request never taken counts as a hang
      if (!req_ready) tmo = 1;
      // Released address and length lines must not keep the old value
      req_valid <= 1'b0;
      req_addr <= ~adr;
      req_len <= ~len;
      // quadlets sent whole, with random stalls
      while (wq.size() > 0 && n < 120) begin
         wr_valid <= ($urandom_range(3) != 0);
         wr_data <= wq[0];
         @(posedge clk);
         n++;
         if (wr_ready && wr_valid) void'(wq.pop_front());
      end
      wr_valid <= 1'b0;
      wr_data <= ~wr_data;
      while (want && !got_done && n < 160) begin
         @(posedge clk);
         n++;
      end
      if (!want) repeat (4) @(posedge clk);
      if (want && !got_done) tmo = 1;
   endtask
endmodule // ciq_host

// ===== ciq_pkg.sv
package ciq_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 48;
   localparam int DATA_W = 32;
   localparam int OFF_W = 12;
   localparam int LEN_W = 6;
   localparam int ID_W = 16;
   localparam int CHAN_W = 2;
   localparam int CODE_W = 4;
   localparam int CAP_BITS = 8;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] WIN_BASE = 48'hFFFF_F0F0_0000;
   localparam logic [OFF_W-1:0] OFF_REINIT = 12'h000;
   localparam logic [OFF_W-1:0] OFF_FMT_CAP = 12'h100;
   localparam logic [OFF_W-1:0] OFF_VGA_CAP = 12'h180;
   localparam logic [OFF_W-1:0] OFF_PART_CAP = 12'h19C;
   localparam logic [ADDR_W-1:0] QUAD_STEP = 48'h0000_0000_0004;
   localparam logic [1:0] QUAD_ALIGN = 2'h0;

   // Bit 0 of a quadlet is its most significant bit
   localparam int BIT0_POS = DATA_W - 1;

   // ---------------------------------------------------------------
   // Capability tables, index i is documented bit i
   // ---------------------------------------------------------------
   localparam logic [CAP_BITS-1:0] FMT_CAP_BITS = 8'h81;
   localparam logic [CAP_BITS-1:0] VGA_CAP_BITS = 8'h6A;
   localparam logic [CAP_BITS-1:0] PART_CAP_MONO = 8'h01;
   localparam logic [CAP_BITS-1:0] PART_CAP_COLOUR = 8'h03;

   // ---------------------------------------------------------------
   // Block transfer limits and answers
   // ---------------------------------------------------------------
   localparam logic [LEN_W-1:0] MAX_QUADS = 6'h20;
   localparam logic [LEN_W-1:0] ONE_QUAD = 6'h01;
   localparam logic [LEN_W-1:0] NO_QUADS = 6'h00;
   localparam logic [CODE_W-1:0] RCODE_COMPLETE = 4'h0;
   localparam logic [CODE_W-1:0] RCODE_TYPE_ERR = 4'h6;
   localparam logic [CODE_W-1:0] RCODE_ADDR_ERR = 4'h7;

   localparam logic [CHAN_W-1:0] FACTORY_CHAN = 2'h0;

   typedef enum logic [1:0] {
      CIQ_IDLE,
      CIQ_RD,
      CIQ_WR
   } ciq_state_e;

endpackage

// ===== ciq_regs.sv
`timescale 1ns/1ps
module ciq_regs (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ciq_pkg::ID_W-1:0] node_id,
   input wire logic colour_strap,
   input wire logic startup_set,
   input wire logic [ciq_pkg::CHAN_W-1:0] startup_chan,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ciq_pkg::ID_W-1:0] req_dest,
   input wire logic [ciq_pkg::ADDR_W-1:0] req_addr,
   input wire logic [ciq_pkg::LEN_W-1:0] req_len,
   input wire logic wr_valid,
   input wire logic [ciq_pkg::DATA_W-1:0] wr_data,
   output logic wr_ready,
   output logic rsp_valid,
   output logic [ciq_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_last,
   output logic done,
   output logic [ciq_pkg::CODE_W-1:0] done_code,
   output logic cam_reset,
   output logic lock_release,
   output logic load_req,
   output logic [ciq_pkg::CHAN_W-1:0] load_chan
);
   import ciq_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      ciq_state_e state;
      logic req_ready;
      logic wr_ready;
      logic [ADDR_W-1:0] addr;
      logic [LEN_W-1:0] left;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_data;
      logic rsp_last;
      logic done;
      logic [CODE_W-1:0] code;
      logic reinit_pend;
      logic cam_reset;
      logic lock_release;
      logic load_req;
      logic [CHAN_W-1:0] load_chan;
      logic boot;
      logic colour;
   } ciq_st_s;

   localparam ciq_st_s ST_RESET = '{
      state: CIQ_IDLE,
      req_ready: 1'b1,
      wr_ready: 1'b0,
      addr: '0,
      left: NO_QUADS,
      rsp_valid: 1'b0,
      rsp_data: '0,
      rsp_last: 1'b0,
      done: 1'b0,
      code: RCODE_COMPLETE,
      reinit_pend: 1'b0,
      cam_reset: 1'b0,
      lock_release: 1'b0,
      load_req: 1'b0,
      load_chan: FACTORY_CHAN,
      boot: 1'b1,
      colour: 1'b0
   };

   ciq_st_s st_r;
   ciq_st_s st_nxt;

   ciq_rom_if rom_if ();

   logic in_win;
   logic at_reinit;
   logic [DATA_W-1:0] rd_word;
   logic last_quad;
   logic len_bad;
   logic [CHAN_W-1:0] start_chan;
   logic req_take;
   logic req_mine;
   logic req_refuse;
   logic [CODE_W-1:0] refuse_code;
   logic beat_take;
   logic reinit_hit;
   logic [ADDR_W-1:0] next_addr;
   logic [LEN_W-1:0] next_left;

   // ---------------------------------------------------------------
   // Capability lookup
   // ---------------------------------------------------------------
   ciq_rom u_rom (
      .rom_if(rom_if)
   );

   assign rom_if.off = st_r.addr[OFF_W-1:0];
   // Strap held in state, so a later pin change cannot alter reads
   assign rom_if.colour = st_r.colour;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // upper bits match window base
   assign in_win = (st_r.addr[ADDR_W-1:OFF_W] == WIN_BASE[ADDR_W-1:OFF_W]);

   assign at_reinit = in_win && (st_r.addr[OFF_W-1:0] == OFF_REINIT);

   always_comb begin
      rd_word = '0;
      // outside window or unmapped gives zero
      if (in_win && rom_if.hit) begin
         rd_word = rom_if.data;
      end
      // Pending request stays visible until taken
      if (at_reinit) begin
         rd_word[BIT0_POS] = st_r.reinit_pend;
      end
   end

   // Block ends when the final quadlet is handled
   assign last_quad = (st_r.left == ONE_QUAD);

   assign len_bad = (req_len == NO_QUADS) || (req_len > MAX_QUADS);

   // factory channel unless one is designated
   assign start_chan = startup_set ? startup_chan : FACTORY_CHAN;

   // ---------------------------------------------------------------
   // Request screening
   // ---------------------------------------------------------------
   // Length is judged before alignment, one code per refusal
   always_comb begin
      req_take = req_valid && st_r.req_ready;
      req_mine = req_take && (req_dest == node_id);
      req_refuse = 1'b0;
      refuse_code = RCODE_COMPLETE;
      if (len_bad) begin
         req_refuse = 1'b1;
         refuse_code = RCODE_TYPE_ERR;
      end else if (req_addr[1:0] != QUAD_ALIGN) begin
         req_refuse = 1'b1;
         refuse_code = RCODE_ADDR_ERR;
      end
   end

   // Beats outside the write phase are never counted
   assign beat_take = wr_valid && st_r.wr_ready;

   // only bit 0 at offset zero acts
   assign reinit_hit = beat_take && at_reinit && wr_data[BIT0_POS];

   // Both phases walk the block one quadlet a step
   assign next_addr = st_r.addr + QUAD_STEP;
   assign next_left = st_r.left - ONE_QUAD;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp_valid = 1'b0;
      st_nxt.rsp_last = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.cam_reset = 1'b0;
      st_nxt.lock_release = 1'b0;
      st_nxt.load_req = 1'b0;

      if (st_r.boot) begin
         // Strap caught one edge after reset release
         st_nxt.boot = 1'b0;
         st_nxt.colour = colour_strap;
         st_nxt.load_req = 1'b1;
         st_nxt.load_chan = start_chan;
      end else if (st_r.reinit_pend) begin
         st_nxt.reinit_pend = 1'b0;
         st_nxt.cam_reset = 1'b1;
         st_nxt.lock_release = 1'b1;
         st_nxt.load_req = 1'b1;
         st_nxt.load_chan = start_chan;
      end

      unique case (st_r.state)
         CIQ_IDLE: begin
            if (req_take) begin
               // Other nodes' traffic is silently dropped
               if (!req_mine) begin
                  st_nxt.req_ready = 1'b1;
               end else if (req_refuse) begin
                  // Refused request leaves the bus free at once
                  st_nxt.done = 1'b1;
                  st_nxt.code = refuse_code;
               end else begin
                  st_nxt.addr = req_addr;
                  st_nxt.left = req_len;
                  st_nxt.req_ready = 1'b0;
                  if (req_write) begin
                     st_nxt.state = CIQ_WR;
                     st_nxt.wr_ready = 1'b1;
                  end else begin
                     st_nxt.state = CIQ_RD;
                  end
               end
            end
         end

         CIQ_RD: begin
            // One quadlet per cycle, no stall
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_data = rd_word;
            st_nxt.rsp_last = last_quad;
            st_nxt.left = next_left;
            st_nxt.addr = next_addr;
            if (last_quad) begin
               st_nxt.done = 1'b1;
               st_nxt.code = RCODE_COMPLETE;
               st_nxt.state = CIQ_IDLE;
               st_nxt.req_ready = 1'b1;
            end
         end

         CIQ_WR: begin
            if (beat_take) begin
               if (reinit_hit) begin
                  // Set wins over the self-clear above
                  st_nxt.reinit_pend = 1'b1;
               end
               st_nxt.left = next_left;
               st_nxt.addr = next_addr;
               if (last_quad) begin
                  st_nxt.wr_ready = 1'b0;
                  st_nxt.done = 1'b1;
                  st_nxt.code = RCODE_COMPLETE;
                  st_nxt.state = CIQ_IDLE;
                  st_nxt.req_ready = 1'b1;
               end
            end
         end

         default: begin
            // Illegal code: recover quietly
            st_nxt.state = CIQ_IDLE;
            st_nxt.req_ready = 1'b1;
            st_nxt.wr_ready = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Reset keeps req_ready high so requests may follow at once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Pulses last one cycle; done_code holds until the next done
   assign req_ready = st_r.req_ready;
   assign wr_ready = st_r.wr_ready;
   assign rsp_valid = st_r.rsp_valid;
   assign rsp_data = st_r.rsp_data;
   assign rsp_last = st_r.rsp_last;
   assign done = st_r.done;
   assign done_code = st_r.code;
   assign cam_reset = st_r.cam_reset;
   assign lock_release = st_r.lock_release;
   assign load_req = st_r.load_req;
   assign load_chan = st_r.load_chan;

endmodule // ciq_regs

// ===== ciq_regs_props.sv
`timescale 1ns/1ps
module ciq_regs_chk (
   input logic clk,
   input logic sys_rst,
   input logic [ciq_pkg::ID_W-1:0] node_id,
   input logic startup_set,
   input logic [ciq_pkg::CHAN_W-1:0] startup_chan,
   input logic req_valid,
   input logic req_ready,
   input logic req_write,
   input logic [ciq_pkg::ID_W-1:0] req_dest,
   input logic [ciq_pkg::ADDR_W-1:0] req_addr,
   input logic [ciq_pkg::LEN_W-1:0] req_len,
   input logic wr_ready,
   input logic rsp_valid,
   input logic [ciq_pkg::DATA_W-1:0] rsp_data,
   input logic rsp_last,
   input logic done,
   input logic [ciq_pkg::CODE_W-1:0] done_code,
   input logic cam_reset,
   input logic lock_release,
   input logic load_req,
   input logic [ciq_pkg::CHAN_W-1:0] load_chan
);
   import ciq_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic take, own, len_ok, good;
   assign take = req_valid && req_ready;
   assign own = req_dest == node_id;
   assign len_ok = req_len != 6'h00 && req_len <= 6'h20;
   assign good = take && own && len_ok && req_addr[1:0] == 2'h0;
   // ------------------------------------------------------------
   // Request handling, reinit pulse and load requests
   // ------------------------------------------------------------
   len_refused_a: assert property (
      take && own && !len_ok && req_addr[1:0] == 2'h0 |=> done && done_code == 4'h6)
      else $error("bad length not refused");
   misalign_refused_a: assert property (
      take && own && len_ok && req_addr[1:0] != 2'h0 |=> done && done_code == 4'h7)
      else $error("misaligned address not refused");
   foreign_dropped_a: assert property (
      take && !own |=> (!done && !rsp_valid) [*3]) else $error("foreign request answered");
   read_start_a: assert property (
      good && !req_write |=> !req_ready ##1 rsp_valid) else $error("read not started");
   write_open_a: assert property (
      good && req_write |=> wr_ready && !req_ready) else $error("write phase not opened");
   fmt_value_a: assert property (
      good && !req_write && req_addr == WIN_BASE + 48'h100 |-> ##2 rsp_data == 32'h8100_0000)
      else $error("format capability wrong");
   vga_value_a: assert property (
      good && !req_write && req_addr == WIN_BASE + 48'h180 |-> ##2 rsp_data == 32'h5600_0000)
      else $error("mode capability wrong");
   last_done_a: assert property (
      rsp_last |-> rsp_valid && done && done_code == 4'h0 && req_ready)
      else $error("last quadlet without completion");
   reinit_pulse_a: assert property (
      $rose(cam_reset) |-> lock_release && load_req ##1 !cam_reset)
      else $error("reinit pulse wrong");
   load_chan_a: assert property (
      load_req |-> load_chan == (startup_set ? startup_chan : 2'h0))
      else $error("load channel wrong");
   boot_load_a: assert property ($past(sys_rst) |=> load_req)
      else $error("no load after reset");
endmodule // ciq_regs_chk
bind ciq_regs ciq_regs_chk i_chk (.clk(clk), .sys_rst(sys_rst), .node_id(node_id),
   .startup_set(startup_set), .startup_chan(startup_chan), .req_valid(req_valid),
   .req_ready(req_ready), .req_write(req_write), .req_dest(req_dest), .req_addr(req_addr),
   .req_len(req_len), .wr_ready(wr_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .rsp_last(rsp_last),
   .done(done), .done_code(done_code), .cam_reset(cam_reset), .lock_release(lock_release),
   .load_req(load_req), .load_chan(load_chan));

// ===== ciq_regs_tb_top.sv
`timescale 1ns/1ps
module ciq_regs_tb_top;
   import ciq_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ID_W-1:0] node_id = '0;
   logic colour_strap = 1'b0;
   logic startup_set = 1'b0;
   logic [CHAN_W-1:0] startup_chan = '0;
   logic req_valid, req_ready, req_write, wr_valid, wr_ready;
   logic rsp_valid, rsp_last, done, cam_reset, lock_release, load_req;
   logic [ID_W-1:0] req_dest;
   logic [ADDR_W-1:0] req_addr;
   logic [LEN_W-1:0] req_len;
   logic [DATA_W-1:0] wr_data, rsp_data;
   logic [CODE_W-1:0] done_code;
   logic [CHAN_W-1:0] load_chan;
   int miscompares = 0;
   int total_checks = 0;
   int resets_seen = 0;
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (cam_reset === 1'b1) resets_seen++;
   end
   ciq_regs i_dut (.clk(clk), .sys_rst(sys_rst), .node_id(node_id),
      .colour_strap(colour_strap), .startup_set(startup_set), .startup_chan(startup_chan),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_dest(req_dest), .req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid),
      .wr_data(wr_data), .wr_ready(wr_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_last(rsp_last), .done(done), .done_code(done_code), .cam_reset(cam_reset),
      .lock_release(lock_release), .load_req(load_req), .load_chan(load_chan));
   ciq_host i_host (.clk(clk), .req_ready(req_ready), .wr_ready(wr_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done), .done_code(done_code),
      .req_valid(req_valid), .req_write(req_write), .req_dest(req_dest),
      .req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid), .wr_data(wr_data));
   // ------------------------------------------------------------
   // Expected quadlet from the documented bit lists
   // ------------------------------------------------------------
   function automatic logic [DATA_W-1:0] exp_q(input logic [OFF_W-1:0] off, input logic col);
      logic [7:0] m;
      logic [DATA_W-1:0] q;
      q = '0;
      case (off)
         12'h100: m = 8'h81;
         12'h180: m = 8'h6A;
         12'h19C: m = col ? 8'h03 : 8'h01;
         default: m = 8'h00;
      endcase
      for (int i = 0; i < 8; i++) q[31 - i] = m[i];
      return q;
   endfunction
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic go(input logic wr, input logic [OFF_W-1:0] off, input int len, input bit own);
      i_host.xfer(wr, own ? node_id : ~node_id, WIN_BASE + off, len[LEN_W-1:0], own);
      if (i_host.tmo) begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic rd(input logic [OFF_W-1:0] off, input int len);
      go(1'b0, off, len, 1'b1);
      chk(i_host.code, RCODE_COMPLETE);
      chk(i_host.rd_q.size(), len);
      for (int k = 0; k < len; k++)
         chk(i_host.rd_q[k], exp_q(off + 12'(4 * k), colour_strap));
   endtask
   task automatic wr(input logic [OFF_W-1:0] off, input int len, input logic [DATA_W-1:0] d0);
      i_host.wq.push_back(d0);
      for (int k = 1; k < len; k++)
         i_host.wq.push_back($urandom);
      go(1'b1, off, len, 1'b1);
      chk(i_host.code, RCODE_COMPLETE);
   endtask
   initial begin
      logic [DATA_W-1:0] d;
      void'($urandom(22656));
      for (int p = 0; p < 2; p++) begin
         colour_strap <= p[0];
         startup_set <= p[0];
         startup_chan <= 2'($urandom);
         node_id <= 16'($urandom);
         sys_rst <= 1'b1;
         repeat (3) @(posedge clk);
         sys_rst <= 1'b0;
         repeat (2) @(posedge clk);
         chk(load_req, 1'b1);
         chk(load_chan, startup_set ? startup_chan : 2'h0);
         rd(12'h100, 32);
         rd(12'h180, 8);
         d = $urandom;
         wr(12'h180, 3, d);
         wr({1'b1, d[10:2], 2'h0}, 1, d);
         rd(12'h17C, 9);
         wr(12'h000, 1, d & 32'h7FFF_FFFF);
         wr(12'h000, 1, 32'h8000_0000);
         repeat (3) @(posedge clk);
         chk(resets_seen, p + 1);
         rd(12'h000, 1);
         go(1'b0, 12'h104, 0, 1'b1);
         chk(i_host.code, RCODE_TYPE_ERR);
         go(1'b1, 12'h104, 33, 1'b1);
         chk(i_host.code, RCODE_TYPE_ERR);
         go(p[0], 12'h102, 1, 1'b1);
         chk(i_host.code, RCODE_ADDR_ERR);
         go(1'b0, 12'h100, 1, 1'b0);
         chk(i_host.got_done, 1'b0);
         repeat (12) begin
            d = $urandom;
            rd({1'b0, d[10:2], 2'h0}, 1 + int'(d[13:12]));
         end
         $display("test phase %0d done", p);
      end
      close_out();
   end
endmodule // ciq_regs_tb_top

// ===== ciq_rom.sv
`timescale 1ns/1ps
module ciq_rom (
   ciq_rom_if.rom rom_if
);
   import ciq_pkg::*;

   logic [DATA_W-1:0] fmt_word;
   logic [DATA_W-1:0] vga_word;
   logic [DATA_W-1:0] part_word;
   logic [CAP_BITS-1:0] part_bits;

   // ---------------------------------------------------------------
   // Capability words
   // ---------------------------------------------------------------
   // variant selects modes
   assign part_bits = rom_if.colour ? PART_CAP_COLOUR : PART_CAP_MONO;

   genvar i;
   generate
      for (i = 0; i < CAP_BITS; i++) begin : g_cap
         assign fmt_word[BIT0_POS-i] = FMT_CAP_BITS[i];
         assign vga_word[BIT0_POS-i] = VGA_CAP_BITS[i];
         assign part_word[BIT0_POS-i] = part_bits[i];
      end
   endgenerate

   assign fmt_word[DATA_W-CAP_BITS-1:0] = '0;
   assign vga_word[DATA_W-CAP_BITS-1:0] = '0;
   assign part_word[DATA_W-CAP_BITS-1:0] = '0;

   // ---------------------------------------------------------------
   // Offset decode
   // ---------------------------------------------------------------
   always_comb begin
      rom_if.data = '0;
      rom_if.hit = 1'b1;
      unique case (rom_if.off)
         OFF_FMT_CAP: rom_if.data = fmt_word;
         OFF_VGA_CAP: rom_if.data = vga_word;
         OFF_PART_CAP: rom_if.data = part_word;
         // Reinit bit is merged in by the owner
         OFF_REINIT: rom_if.data = '0;
         default: rom_if.hit = 1'b0;
      endcase
   end

endmodule // ciq_rom

// ===== ciq_rom_if.sv
`timescale 1ns/1ps
interface ciq_rom_if;
   logic [ciq_pkg::OFF_W-1:0] off;
   logic colour;
   logic [ciq_pkg::DATA_W-1:0] data;
   logic hit;

   modport client (
      output off,
      output colour,
      input data,
      input hit
   );

   modport rom (
      input off,
      input colour,
      output data,
      output hit
   );
endinterface
